// [hw/plm_pkg.sv]
// Purpose: Shared constants for the pixel lookup table mapper
// Assumes: One pixel clock drives every part of the block
// Notes: Output format codes and table geometry live here
package plm_pkg;
  // Pixel and mapped widths
  localparam int PIX_W = 12;
  localparam int MAP_W = 8;
  localparam int OUT_W = 12;
  localparam int FRAC_W = 2;
  // Table geometry: entries every 4 codes, 0 through 4096
  localparam int IDX_W = 13;
  localparam int TBL_AW = 11;
  localparam int TBL_DEPTH = 1025;
  localparam logic [TBL_AW-1:0] TOP_ENTRY = 11'h400;
  localparam logic [IDX_W-1:0] IDX_STEP = 13'h0004;
  // Output format codes
  localparam int FMT_W = 2;
  localparam logic [FMT_W-1:0] FMT_8 = 2'h0;
  localparam logic [FMT_W-1:0] FMT_10 = 2'h1;
  localparam logic [FMT_W-1:0] FMT_12 = 2'h2;
  // Table mode field
  localparam int MODE_W = 1;
  localparam logic [MODE_W-1:0] MODE_ON = 1'h1;
  // Reset values
  localparam logic [IDX_W-1:0] IDX_RST = 13'h0000;
  localparam logic [MODE_W-1:0] MODE_RST = 1'h0;
  localparam logic [FMT_W-1:0] FMT_RST = 2'h0;
  // Output buffer depth
  localparam int FIFO_DEPTH = 16;
endpackage : plm_pkg

// [hw/plm_fifo.sv]
// Purpose: Synchronous FIFO with valid and ready on both sides
// Assumes: DEPTH is a power of two
// Notes: Ready and valid are combinational from the occupancy count
`timescale 1ns/1ps
module plm_fifo
  import plm_pkg::*;
#(
  parameter int WIDTH = OUT_W,
  parameter int DEPTH = FIFO_DEPTH
)
(
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;

  // Handshake terms
  assign in_ready_o = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid_o = (cnt_q != '0);
  assign push = ce_i && in_valid_i && in_ready_o;
  assign pop = ce_i && out_valid_o && out_ready_i;
  assign out_data_o = mem_q[rd_ptr_q];

  // Storage writes
  always_ff @(posedge core_clk_i)
  begin
    if (push)
    begin
      mem_q[wr_ptr_q] <= in_data_i;
    end
  end

  // Pointers and occupancy
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      cnt_q <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_q <= wr_ptr_q + AW'(1);
      end
      if (pop)
      begin
        rd_ptr_q <= rd_ptr_q + AW'(1);
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  AST_FIFO_BOUND: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    cnt_q <= (AW+1)'(DEPTH))
    else $error("FIFO occupancy above depth");
  AST_FIFO_COUNT: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (push && !pop) |=> (cnt_q == $past(cnt_q) + (AW+1)'(1)))
    else $error("FIFO count did not rise on push");
endmodule : plm_fifo

// [hw/plm_mapper.sv]
// Purpose: Maps 12-bit sensor pixels to 8-bit values through an interpolating table
// Assumes: Pixel stream and configuration ports share core_clk_i
// Notes: Two register stages then a 16-word output FIFO; FIFO back-pressure stalls the pipe
//
// Behaviour
// - Table off, 8-bit format: output is pixel with four low bits dropped.
// - Table on, 10/12-bit format: mapped byte in MSBs, low 2/4 bits zero.
// - Table holds 1025 8-bit entries at codes 0,4,...,4096.
// - Table on: pixel equal to an index outputs that entry.
// - Table on: pixel between indices interpolates linearly between neighbour entries.
// - Top entry only serves as upper point for pixels 4092 to 4095.
// - Value write stores byte at most recently written index.
// - Mapping applies only while mode field holds enable; else truncation, or the pixel unchanged in 12-bit format.
// - Table contents can be read out and written back for save and restore.
`timescale 1ns/1ps
module plm_mapper
  import plm_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  input wire logic [MODE_W-1:0] lut_mode_i,
  input wire logic [FMT_W-1:0] out_fmt_i,
  input wire logic idx_wr_i,
  input wire logic [IDX_W-1:0] idx_wdata_i,
  input wire logic val_wr_i,
  input wire logic [MAP_W-1:0] val_wdata_i,
  input wire logic tbl_rd_i,
  input wire logic [TBL_AW-1:0] tbl_rd_addr_i,
  output logic [MAP_W-1:0] tbl_rd_data_o,
  output logic tbl_rd_valid_o,
  output logic [IDX_W-1:0] idx_o,
  input wire logic pix_valid_i,
  output logic pix_ready_o,
  input wire logic [PIX_W-1:0] pix_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [OUT_W-1:0] out_data_o
);
  // Converts a pixel or index code to its table entry
  function automatic logic [TBL_AW-1:0] code_to_entry(input logic [IDX_W-1:0] code);
    code_to_entry = code[IDX_W-1:2];
  endfunction : code_to_entry

  logic [MAP_W-1:0] tbl_q [TBL_DEPTH];
  logic [IDX_W-1:0] idx_q;
  logic [PIX_W-1:0] s1_pix_q;
  logic [MAP_W-1:0] s1_lo_q;
  logic [MAP_W-1:0] s1_hi_q;
  logic s1_en_q;
  logic [FMT_W-1:0] s1_fmt_q;
  logic s1_v_q;
  logic [OUT_W-1:0] s2_data_q;
  logic s2_en_q;
  logic [FMT_W-1:0] s2_fmt_q;
  logic s2_v_q;
  logic [MAP_W-1:0] rd_data_q;
  logic rd_v_q;
  logic fifo_ready;
  logic adv;
  logic take;
  logic [TBL_AW-1:0] lo_addr;
  logic [TBL_AW-1:0] hi_addr;
  logic [TBL_AW-1:0] wr_addr;
  logic [MAP_W-1:0] diff;
  logic [MAP_W+FRAC_W-1:0] prod;
  logic [MAP_W-1:0] step;
  logic [MAP_W-1:0] mapped;
  logic [OUT_W-1:0] s2_d;

  // Pipe moves only when the FIFO can take the last stage
  assign adv = ce_i && fifo_ready;
  assign take = adv && pix_valid_i;
  assign pix_ready_o = adv;
  assign lo_addr = code_to_entry({1'b0, pix_data_i});
  assign hi_addr = code_to_entry({1'b0, pix_data_i} + IDX_STEP); // Reaches top entry for 4092..4095
  assign wr_addr = code_to_entry(idx_q);
  assign idx_o = idx_q;
  assign tbl_rd_data_o = rd_data_q;
  assign tbl_rd_valid_o = rd_v_q;

  // Index register, captured on every index write
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      idx_q <= IDX_RST;
    end
    else if (ce_i && idx_wr_i)
    begin
      idx_q <= idx_wdata_i;
    end
  end

  // Table store: 1025 entries, writes beyond top index are dropped
  always_ff @(posedge core_clk_i)
  begin
    if (ce_i && val_wr_i && (wr_addr <= TOP_ENTRY))
    begin
      tbl_q[wr_addr] <= val_wdata_i;
    end
  end

  // Readback port for saving the table to non-volatile memory
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      rd_v_q <= 1'b0;
      rd_data_q <= '0;
    end
    else if (ce_i)
    begin
      rd_v_q <= tbl_rd_i;
      if (tbl_rd_i && (tbl_rd_addr_i <= TOP_ENTRY))
      begin
        rd_data_q <= tbl_q[tbl_rd_addr_i];
      end
      else if (tbl_rd_i)
      begin
        rd_data_q <= '0;
      end
    end
  end

  // Stage 1: fetch the lower and upper neighbour entries
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      s1_v_q <= 1'b0;
      s1_pix_q <= '0;
      s1_lo_q <= '0;
      s1_hi_q <= '0;
      s1_en_q <= 1'b0;
      s1_fmt_q <= FMT_RST;
    end
    else if (adv)
    begin
      s1_v_q <= take;
      if (take)
      begin
        s1_pix_q <= pix_data_i;
        s1_lo_q <= tbl_q[lo_addr]; // Lower entry never the top one
        s1_hi_q <= tbl_q[hi_addr];
        s1_en_q <= (lut_mode_i == MODE_ON);
        s1_fmt_q <= out_fmt_i;
      end
    end
  end

  // Interpolation by magnitude so the result truncates toward the lower entry
  always_comb
  begin
    diff = (s1_hi_q >= s1_lo_q) ? (s1_hi_q - s1_lo_q) : (s1_lo_q - s1_hi_q);
    prod = {2'b00, diff} * {8'h00, s1_pix_q[FRAC_W-1:0]};
    step = prod[MAP_W+FRAC_W-1:FRAC_W];
    mapped = (s1_hi_q >= s1_lo_q) ? (s1_lo_q + step) : (s1_lo_q - step);
  end

  // Output formatting by mode and format
  always_comb
  begin
    s2_d = '0;
    if (s1_en_q)
    begin
      unique case (s1_fmt_q)
        FMT_10: s2_d = {2'b00, mapped, 2'b00};
        FMT_12: s2_d = {mapped, 4'h0};
        default: s2_d = {4'h0, mapped};
      endcase
    end
    else
    begin
      unique case (s1_fmt_q)
        FMT_10: s2_d = {2'b00, s1_pix_q[PIX_W-1:2]};
        FMT_12: s2_d = s1_pix_q;
        default: s2_d = {4'h0, s1_pix_q[PIX_W-1:4]};
      endcase
    end
  end

  // Stage 2: registered output word
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      s2_v_q <= 1'b0;
      s2_data_q <= '0;
      s2_en_q <= 1'b0;
      s2_fmt_q <= FMT_RST;
    end
    else if (adv)
    begin
      s2_v_q <= s1_v_q;
      if (s1_v_q)
      begin
        s2_data_q <= s2_d;
        s2_en_q <= s1_en_q;
        s2_fmt_q <= s1_fmt_q;
      end
    end
  end

  // Output buffer; its ready stalls the whole pipe
  plm_fifo #(
    .WIDTH(OUT_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .core_clk_i(core_clk_i),
    .sys_rst_i(sys_rst_i),
    .ce_i(ce_i),
    .in_valid_i(s2_v_q),
    .in_ready_o(fifo_ready),
    .in_data_i(s2_data_q),
    .out_valid_o(out_valid_o),
    .out_ready_i(out_ready_i),
    .out_data_o(out_data_o)
  );

  AST_TRUNC: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (adv && s1_v_q && !s1_en_q && s1_fmt_q == FMT_8) |=> (s2_data_q == {4'h0, $past(s1_pix_q[11:4])}))
    else $error("Truncation output wrong");
  AST_PAD: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (s2_v_q && s2_en_q && s2_fmt_q == FMT_10) |-> (s2_data_q[1:0] == 2'b00 && s2_data_q[11:10] == 2'b00))
    else $error("10-bit mapped output not padded");
  AST_PAD12: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (s2_v_q && s2_en_q && s2_fmt_q == FMT_12) |-> (s2_data_q[3:0] == 4'h0))
    else $error("12-bit mapped output not padded");
  AST_EXACT: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (adv && s1_v_q && s1_en_q && s1_fmt_q == FMT_8 && s1_pix_q[1:0] == 2'b00)
    |=> (s2_data_q == {4'h0, $past(s1_lo_q)}))
    else $error("Exact index did not output its entry");
  AST_BETWEEN: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (s1_v_q && s1_en_q)
    |-> ((mapped >= s1_lo_q && mapped <= s1_hi_q) || (mapped <= s1_lo_q && mapped >= s1_hi_q)))
    else $error("Interpolation outside neighbour entries");
  AST_TOP: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (hi_addr == TOP_ENTRY) |-> (lo_addr == TOP_ENTRY - 11'h001))
    else $error("Top entry used other than as upper point");
  AST_WRITE: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (ce_i && val_wr_i && wr_addr <= TOP_ENTRY) |=> (tbl_q[$past(wr_addr)] == $past(val_wdata_i)))
    else $error("Value write not stored at index");
  AST_INDEX: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (ce_i && idx_wr_i) |=> (idx_q == $past(idx_wdata_i)) ##1 ($past(ce_i && idx_wr_i) || idx_q == $past(idx_q)))
    else $error("Index register not held");
  AST_MODE: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    take |=> (s1_en_q == ($past(lut_mode_i) == MODE_ON)))
    else $error("Mode not captured with pixel");
  AST_READ: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (ce_i && tbl_rd_i && tbl_rd_addr_i <= TOP_ENTRY && !val_wr_i)
    |=> (tbl_rd_valid_o && tbl_rd_data_o == tbl_q[$past(tbl_rd_addr_i)]))
    else $error("Readback data wrong");
  AST_ROUND: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (s1_v_q && s1_pix_q[1:0] == 2'b10 && s1_hi_q >= s1_lo_q)
    |-> (mapped == s1_lo_q + MAP_W'((s1_hi_q - s1_lo_q) >> 1)))
    else $error("Half-step interpolation wrong");

  COV_MAPPED: cover property (@(posedge core_clk_i) s2_v_q && s2_en_q && s2_fmt_q == FMT_8);
  COV_TRUNC: cover property (@(posedge core_clk_i) s2_v_q && !s2_en_q && s2_fmt_q == FMT_8);
  COV_TOP: cover property (@(posedge core_clk_i) take && pix_data_i == 12'hFFF);
  COV_STALL: cover property (@(posedge core_clk_i) ce_i && !fifo_ready && pix_valid_i);
endmodule : plm_mapper

// [bench/plm_sink_model.sv]
// Purpose: Output-side model that takes mapped words from the mapper
// Assumes: Bench sets stall and slow controls away from the rising edge
// Notes: Captured words queue up in got for the bench to compare
`timescale 1ns/1ps
module plm_sink_model
  import plm_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic ce_i,
  input wire logic stall_i,
  input wire logic slow_i,
  input wire logic out_valid_i,
  input wire logic [OUT_W-1:0] out_data_i,
  output logic out_ready_o
);
  logic [OUT_W-1:0] got[$];
  initial out_ready_o = 1'b0;
  // Ready moves on the falling edge; slow mode accepts every other cycle
  always @(negedge core_clk_i)
  begin
    out_ready_o <= !stall_i && !(slow_i && out_ready_o);
  end
  // Capture each word at its handshake
  always @(posedge core_clk_i)
  begin
    if (ce_i && out_valid_i && out_ready_o)
    begin
      got.push_back(out_data_i);
    end
  end
endmodule : plm_sink_model

// [bench/plm_mapper_bench.sv]
// Purpose: Self-checking bench for the pixel lookup table mapper
// Assumes: Inputs change on the falling edge of a 200 MHz clock
// Notes: Keeps its own copy of the table to work out expected words
`timescale 1ns/1ps
module plm_mapper_bench
  import plm_pkg::*;
;
  logic core_clk_i = 1'b0, sys_rst_i = 1'b1, ce_i = 1'b1;
  logic [MODE_W-1:0] lut_mode_i = '0;
  logic [FMT_W-1:0] out_fmt_i = '0;
  logic idx_wr_i = 1'b0, val_wr_i = 1'b0, tbl_rd_i = 1'b0, pix_valid_i = 1'b0;
  logic [IDX_W-1:0] idx_wdata_i = '0;
  logic [MAP_W-1:0] val_wdata_i = '0, tbl_rd_data_o;
  logic [TBL_AW-1:0] tbl_rd_addr_i = '0;
  logic [PIX_W-1:0] pix_data_i = '0;
  logic [IDX_W-1:0] idx_o;
  logic [OUT_W-1:0] out_data_o;
  logic tbl_rd_valid_o, pix_ready_o, out_valid_o, out_ready_i, stall, slow;
  int n_mismatch = 0, compares = 0, tb[0:1024], exq[$], n, k;
  int pc[20] = '{0, 4, 8, 9, 10, 11, 5, 6, 7, 14, 4092, 4093, 4095, 9, 9, 4094, 2748, 2748, 2748, 2748};
  int pf[20] = '{0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 1, 2, 2, 0, 1, 2, 3};

  plm_mapper dut_u (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i), .lut_mode_i(lut_mode_i),
    .out_fmt_i(out_fmt_i), .idx_wr_i(idx_wr_i), .idx_wdata_i(idx_wdata_i), .val_wr_i(val_wr_i),
    .val_wdata_i(val_wdata_i), .tbl_rd_i(tbl_rd_i), .tbl_rd_addr_i(tbl_rd_addr_i), .tbl_rd_data_o(tbl_rd_data_o),
    .tbl_rd_valid_o(tbl_rd_valid_o), .idx_o(idx_o), .pix_valid_i(pix_valid_i), .pix_ready_o(pix_ready_o),
    .pix_data_i(pix_data_i), .out_valid_o(out_valid_o), .out_ready_i(out_ready_i), .out_data_o(out_data_o));
  plm_sink_model sink_u (.core_clk_i(core_clk_i), .ce_i(ce_i), .stall_i(stall), .slow_i(slow),
    .out_valid_i(out_valid_o), .out_data_i(out_data_o), .out_ready_o(out_ready_i));

  // Clock at 5 ns period
  initial forever #2.5 core_clk_i = ~core_clk_i;

  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask : chk

  task automatic wrap_up();
    if (n_mismatch == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : wrap_up

  // Index write, then value write on the next cycle
  task automatic wr(int c, int v);
    @(negedge core_clk_i);
    idx_wr_i = 1'b1;
    idx_wdata_i = c[IDX_W-1:0];
    @(negedge core_clk_i);
    idx_wr_i = 1'b0;
    val_wr_i = 1'b1;
    val_wdata_i = v[MAP_W-1:0];
    chk("idx_o", 32'(idx_o), c);
    @(negedge core_clk_i);
    val_wr_i = 1'b0;
    tb[c >> 2] = v;
  endtask : wr

  task automatic rd(int a, int exp);
    @(negedge core_clk_i);
    tbl_rd_i = 1'b1;
    tbl_rd_addr_i = a[TBL_AW-1:0];
    @(negedge core_clk_i);
    tbl_rd_i = 1'b0;
    chk("rd_valid", 32'(tbl_rd_valid_o), 1);
    chk("rd_data", 32'(tbl_rd_data_o), exp);
  endtask : rd

  function automatic int xp(int c, bit on, int f);
    int lo, hi, r, m;
    lo = tb[c >> 2];
    hi = tb[(c >> 2) + 1];
    r = c & 3;
    m = (hi >= lo) ? lo + (((hi - lo) * r) >> 2) : lo - (((lo - hi) * r) >> 2);
    if (!on)
      return (f == 2) ? c : (f == 1) ? c >> 2 : c >> 4;
    return (f == 2) ? m << 4 : (f == 1) ? m << 2 : m;
  endfunction : xp

  // One pixel; valid stays high so calls run back to back
  task automatic send(int c, bit on, int f);
    int w;
    @(negedge core_clk_i);
    pix_valid_i = 1'b1;
    pix_data_i = c[PIX_W-1:0];
    lut_mode_i = on;
    out_fmt_i = f[FMT_W-1:0];
    w = 0;
    while (pix_ready_o !== 1'b1 && w < 200)
    begin
      @(negedge core_clk_i);
      w++;
    end
    @(posedge core_clk_i);
    exq.push_back(xp(c, on, f));
  endtask : send

  // Watchdog cuts a hang short
  initial
  begin
    #100000;
    n_mismatch++;
    wrap_up();
  end

  // Main sequence
  initial
  begin
    stall = 1'b0;
    slow = 1'b1;
    repeat (5) @(negedge core_clk_i);
    sys_rst_i = 1'b0;
    chk("idx_o", 32'(idx_o), 0);
    chk("out_valid", 32'(out_valid_o), 0);
    wr(0, 5); wr(4, 128); wr(8, 64); wr(12, 16); wr(16, 51); wr(4092, 240); wr(4096, 255);
    rd(2, 64);
    rd(1024, 255);
    rd(1025, 0);
    for (int i = 0; i < 20; i++)
      send(pc[i], i < 16, pf[i]);
    @(negedge core_clk_i);
    pix_valid_i = 1'b0;
    k = 0;
    while (sink_u.got.size() < 20 && k < 300)
    begin
      @(negedge core_clk_i);
      k++;
    end
    stall = 1'b1;
    @(negedge core_clk_i);
    pix_valid_i = 1'b1;
    pix_data_i = 12'h123;
    lut_mode_i = 1'h0;
    out_fmt_i = FMT_12;
    n = 0;
    // Ready seen at a falling edge decides acceptance at the next rising edge
    repeat (40)
    begin
      if (pix_ready_o === 1'b1) n++;
      @(negedge core_clk_i);
    end
    pix_valid_i = 1'b0;
    repeat (n) exq.push_back(12'h123);
    chk("fill_count", n, 18);
    chk("full_ready", 32'(pix_ready_o), 0);
    ce_i = 1'b0;
    stall = 1'b0;
    slow = 1'b0;
    @(negedge core_clk_i);
    chk("ce_ready", 32'(pix_ready_o), 0);
    ce_i = 1'b1;
    k = 0;
    while (sink_u.got.size() < exq.size() && k < 300)
    begin
      @(negedge core_clk_i);
      k++;
    end
    chk("word_count", sink_u.got.size(), exq.size());
    foreach (exq[i])
      chk("out_data", 32'(sink_u.got[i]), exq[i]);
    // Reset again mid-run with a nonzero index and readback word standing
    rd(2, 64);
    @(negedge core_clk_i);
    sys_rst_i = 1'b1;
    repeat (2) @(negedge core_clk_i);
    sys_rst_i = 1'b0;
    chk("rst_idx", 32'(idx_o), 0);
    chk("rst_rd_data", 32'(tbl_rd_data_o), 0);
    chk("rst_rd_valid", 32'(tbl_rd_valid_o), 0);
    chk("rst_out_valid", 32'(out_valid_o), 0);
    wrap_up();
  end
endmodule : plm_mapper_bench
